// *** rtl/pmd_pkg.sv ***
// Purpose: shared constants and state types of the message and doorbell unit
// Assumes: one clock domain, register offsets are 12-bit window offsets
// Notes: all offsets are byte offsets inside the messaging window
package pmd_pkg;

  localparam int DATA_W = 32;
  localparam int OFF_W = 12;

  // register offsets inside the window
  localparam logic [11:0] OFF_IN_MSG0 = 12'h010;
  localparam logic [11:0] OFF_IN_MSG1 = 12'h014;
  localparam logic [11:0] OFF_OUT_MSG0 = 12'h018;
  localparam logic [11:0] OFF_OUT_MSG1 = 12'h01c;
  localparam logic [11:0] OFF_IN_BELL = 12'h020;
  localparam logic [11:0] OFF_IN_CAUSE = 12'h024;
  localparam logic [11:0] OFF_IN_MASK = 12'h028;
  localparam logic [11:0] OFF_OUT_BELL = 12'h02c;
  localparam logic [11:0] OFF_OUT_CAUSE = 12'h030;
  localparam logic [11:0] OFF_OUT_MASK = 12'h034;

  // window placement
  localparam logic [15:0] CPU_WIN_BASE = 16'h1c00;
  localparam int CPU_SPAN_LOG2 = 10;
  localparam logic [31:0] PCI_WIN_BASE = 32'h0000_0000;
  localparam int PCI_SPAN_LOG2 = 12;

  // inbound cause and mask bit positions
  localparam int IN_MSG0_BIT = 0;
  localparam int IN_MSG1_BIT = 1;
  localparam int IN_BELL_BIT = 2;
  localparam int IN_PQ_BIT = 4;
  localparam int IN_FQ_BIT = 5;
  localparam logic [5:0] IN_MASK_VALID = 6'h37;
  localparam logic [31:0] IN_CAUSE_VALID = 32'h0000_0037;

  // outbound cause and mask bit positions
  localparam int OUT_MSG0_BIT = 0;
  localparam int OUT_MSG1_BIT = 1;
  localparam int OUT_BELL_BIT = 2;
  localparam int OUT_PQ_BIT = 3;

  // reset values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [5:0] IN_MASK_RST = 6'h00;
  localparam logic [3:0] OUT_MASK_RST = 4'h0;

  typedef struct packed {
    logic strap_done;
    logic enabled;
    logic [31:0] in_message_zero;
    logic [31:0] in_message_one;
    logic [31:0] out_message_zero;
    logic [31:0] out_message_one;
    logic [1:0] in_msg_cause;
    logic in_post_queue_event;
    logic out_free_queue_full_event;
    logic fq_full_d;
    logic [1:0] out_msg_cause;
    logic [5:0] in_mask;
    logic [3:0] out_mask;
    logic cpu_ack;
    logic [31:0] cpu_rdata;
    logic pci0_ack;
    logic [31:0] pci0_rdata;
    logic pci0_to_sdram;
    logic pci1_to_sdram;
    logic cpu_irq;
    logic pci_irq;
  } pmd_state_t;

  typedef struct packed {
    logic [31:0] bits;
  } pmd_bell_t;

endpackage

// *** rtl/pmd_acc_if.sv ***
// Purpose: one decoded register access from a port into the unit
// Assumes: combinational, valid for the cycle of the request only
// Notes: sel is a hit on an enabled window, miss is any request that is not a hit
interface pmd_acc_if;
  logic sel;
  logic wr;
  logic miss;
  logic [11:0] off;
  logic [31:0] wdata;
  modport src (output sel, wr, miss, off, wdata);
  modport dst (input sel, wr, miss, off, wdata);
endinterface

// *** rtl/pmd_port.sv ***
// Purpose: window decode of one access port
// Assumes: address is already relative to the port's space base
// Notes: no state, answers are registered by the caller
module pmd_port #(
  parameter int ADDR_W = 16,
  parameter logic [ADDR_W-1:0] BASE = '0,
  parameter int SPAN_LOG2 = 12
) (
  // control
  input wire logic en,
  // request
  input wire logic valid,
  input wire logic wr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  // decoded access
  pmd_acc_if.src acc
);

  logic in_win;

  // window match on the upper address bits
  assign in_win = addr[ADDR_W-1:SPAN_LOG2] == BASE[ADDR_W-1:SPAN_LOG2];
  assign acc.sel = valid && en && in_win;
  assign acc.miss = valid && !(en && in_win);
  assign acc.wr = wr;
  assign acc.off = 12'(addr[SPAN_LOG2-1:0]);
  assign acc.wdata = wdata;

endmodule

// *** rtl/pmd_bell.sv ***
// Purpose: 32 sticky doorbell bits, one party sets and the other clears
// Assumes: set and clear are one-cycle masks
// Notes: a bit set and cleared in one cycle stays set
module pmd_bell (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // set and clear masks
  input wire logic [31:0] set_bits,
  input wire logic [31:0] clr_bits,
  // state
  output logic [31:0] bits
);

  pmd_pkg::pmd_bell_t s;
  pmd_pkg::pmd_bell_t n;

  always_comb
  begin
    n = s;
    // zero bits in both masks leave the bit alone
    n.bits = (s.bits & ~clr_bits) | set_bits;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '{bits: pmd_pkg::WORD_RST};
    else
      s <= n;
  end

  assign bits = s.bits;

  bell_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    |set_bits |=> ((bits & $past(set_bits)) == $past(set_bits)))
    else $error("doorbell set bit not held");

  bell_clear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    |(clr_bits & ~set_bits) |=> ((bits & $past(clr_bits) & ~$past(set_bits)) == '0))
    else $error("doorbell clear bit not cleared");

endmodule

// *** rtl/pmd_top.sv ***
// Purpose: message registers, doorbells and interrupt causes between cpu and pci
// Assumes: all inputs synchronous to ref_clk, one request per cycle per port
// Notes: every window hit gets a one-cycle answer one clock after it is taken
// Functional notes
// - registers reachable only when the enable strap was low at reset.
// - cpu offsets decode relative to internal base plus fixed displacement.
// - first pci port reaches registers in first 4 KB of its sdram window.
// - second pci port never reaches registers; its accesses go to sdram.
// - inbound messages written by pci, read-only to cpu, set cause bits.
// - outbound messages written by cpu, read-only to pci, set outbound causes.
// - pci writing one to an inbound doorbell bit sets it.
// - cpu writing one clears inbound doorbell bit; interrupt drops when none set.
// - inbound cause bits 0 and 1 set on message writes, cpu clears.
// - inbound cause bit 2 shows any inbound doorbell bit set.
// - inbound cause bit 4 sets on post queue write, cpu clears.
// - inbound cause bit 5 sets when free queue becomes full, cpu clears.
// - cpu interrupt when any unmasked inbound cause bit 0,1,2,4,5 set.
// - inbound cause bit 3 and bits 31:6 read zero, no interrupt.
// - inbound mask bits 0,1,2,4,5 suppress sources, reset to zero.
// - outbound cause bits 0,1 set on outbound writes, pci clears.
// - cpu one sets outbound doorbell bit, pci one clears it.
// - pci interrupt when any unmasked outbound cause bit 0 to 3 set.
module pmd_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // strap
  input wire logic messaging_enable_strap,
  // cpu internal register port
  input wire logic cpu_valid,
  input wire logic cpu_wr,
  input wire logic [15:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_ack,
  output logic [31:0] cpu_rdata,
  // first pci port, sdram bank-pair window
  input wire logic pci0_bar_valid,
  input wire logic pci0_wr,
  input wire logic [31:0] pci0_addr,
  input wire logic [31:0] pci0_wdata,
  output logic pci0_ack,
  output logic [31:0] pci0_rdata,
  output logic pci0_to_sdram,
  // second pci port, sdram bank-pair window
  input wire logic pci1_bar_valid,
  output logic pci1_to_sdram,
  // queue events
  input wire logic in_post_queue_write,
  input wire logic out_free_queue_full,
  input wire logic out_post_queue_not_empty,
  // interrupts
  output logic cpu_irq,
  output logic pci_irq
);

  pmd_pkg::pmd_state_t s;
  pmd_pkg::pmd_state_t n;

  pmd_acc_if cpu_acc();
  pmd_acc_if pci_acc();

  logic cw;
  logic cr;
  logic pw;
  logic pr;
  logic [31:0] in_bell_bits;
  logic [31:0] out_bell_bits;
  logic [31:0] in_bell_set;
  logic [31:0] in_bell_clr;
  logic [31:0] out_bell_set;
  logic [31:0] out_bell_clr;
  logic [31:0] in_cause_word;
  logic [31:0] out_cause_word;
  logic [31:0] in_clr;
  logic [31:0] out_clr;

  // write strobe for one register offset
  function automatic logic hit(input logic w, input logic [11:0] off,
                               input logic [11:0] target);
    return w && (off == target);
  endfunction

  // read view shared by both ports
  function automatic logic [31:0] reg_read(input logic [11:0] off,
                                           input pmd_pkg::pmd_state_t st,
                                           input logic [31:0] icw,
                                           input logic [31:0] ocw,
                                           input logic [31:0] ib,
                                           input logic [31:0] ob);
    logic [31:0] v;
    v = pmd_pkg::WORD_RST;
    unique case (off)
      pmd_pkg::OFF_IN_MSG0: v = st.in_message_zero;
      pmd_pkg::OFF_IN_MSG1: v = st.in_message_one;
      pmd_pkg::OFF_OUT_MSG0: v = st.out_message_zero;
      pmd_pkg::OFF_OUT_MSG1: v = st.out_message_one;
      pmd_pkg::OFF_IN_BELL: v = ib;
      pmd_pkg::OFF_IN_CAUSE: v = icw;
      pmd_pkg::OFF_IN_MASK: v = {26'h0, st.in_mask};
      pmd_pkg::OFF_OUT_BELL: v = ob;
      pmd_pkg::OFF_OUT_CAUSE: v = ocw;
      pmd_pkg::OFF_OUT_MASK: v = {28'h0, st.out_mask};
      default: v = pmd_pkg::WORD_RST;
    endcase
    return v;
  endfunction

  // port decoders
  pmd_port #(
    .ADDR_W(16),
    .BASE(pmd_pkg::CPU_WIN_BASE),
    .SPAN_LOG2(pmd_pkg::CPU_SPAN_LOG2)
  ) u_cpu_port (
    .en(s.enabled),
    .valid(cpu_valid),
    .wr(cpu_wr),
    .addr(cpu_addr),
    .wdata(cpu_wdata),
    .acc(cpu_acc.src)
  );

  pmd_port #(
    .ADDR_W(32),
    .BASE(pmd_pkg::PCI_WIN_BASE),
    .SPAN_LOG2(pmd_pkg::PCI_SPAN_LOG2)
  ) u_pci_port (
    .en(s.enabled),
    .valid(pci0_bar_valid),
    .wr(pci0_wr),
    .addr(pci0_addr),
    .wdata(pci0_wdata),
    .acc(pci_acc.src)
  );

  assign cw = cpu_acc.sel && cpu_acc.wr;
  assign cr = cpu_acc.sel && !cpu_acc.wr;
  assign pw = pci_acc.sel && pci_acc.wr;
  assign pr = pci_acc.sel && !pci_acc.wr;

  // doorbell masks
  assign in_bell_set = hit(pw, pci_acc.off, pmd_pkg::OFF_IN_BELL) ? pci_acc.wdata : '0;
  assign in_bell_clr = hit(cw, cpu_acc.off, pmd_pkg::OFF_IN_BELL) ? cpu_acc.wdata : '0;
  assign out_bell_set = hit(cw, cpu_acc.off, pmd_pkg::OFF_OUT_BELL) ? cpu_acc.wdata : '0;
  assign out_bell_clr = hit(pw, pci_acc.off, pmd_pkg::OFF_OUT_BELL) ? pci_acc.wdata : '0;

  pmd_bell u_in_bell (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .set_bits(in_bell_set),
    .clr_bits(in_bell_clr),
    .bits(in_bell_bits)
  );

  pmd_bell u_out_bell (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .set_bits(out_bell_set),
    .clr_bits(out_bell_clr),
    .bits(out_bell_bits)
  );

  // cause words as software sees them
  always_comb
  begin
    in_cause_word = pmd_pkg::WORD_RST;
    in_cause_word[pmd_pkg::IN_MSG0_BIT] = s.in_msg_cause[0];
    in_cause_word[pmd_pkg::IN_MSG1_BIT] = s.in_msg_cause[1];
    in_cause_word[pmd_pkg::IN_BELL_BIT] = |in_bell_bits;
    in_cause_word[pmd_pkg::IN_PQ_BIT] = s.in_post_queue_event;
    in_cause_word[pmd_pkg::IN_FQ_BIT] = s.out_free_queue_full_event;
    out_cause_word = pmd_pkg::WORD_RST;
    out_cause_word[pmd_pkg::OUT_MSG0_BIT] = s.out_msg_cause[0];
    out_cause_word[pmd_pkg::OUT_MSG1_BIT] = s.out_msg_cause[1];
    out_cause_word[pmd_pkg::OUT_BELL_BIT] = |out_bell_bits;
    out_cause_word[pmd_pkg::OUT_PQ_BIT] = out_post_queue_not_empty;
  end

  // write-one-to-clear masks, cpu for inbound, pci for outbound
  assign in_clr = hit(cw, cpu_acc.off, pmd_pkg::OFF_IN_CAUSE) ? cpu_acc.wdata : '0;
  assign out_clr = hit(pw, pci_acc.off, pmd_pkg::OFF_OUT_CAUSE) ? pci_acc.wdata : '0;

  always_comb
  begin
    n = s;
    // strap taken on the first edge after reset release
    if (!s.strap_done)
    begin
      n.strap_done = 1'b1;
      n.enabled = !messaging_enable_strap;
    end
    // message words, each written only from its own side
    if (hit(pw, pci_acc.off, pmd_pkg::OFF_IN_MSG0))
      n.in_message_zero = pci_acc.wdata;
    if (hit(pw, pci_acc.off, pmd_pkg::OFF_IN_MSG1))
      n.in_message_one = pci_acc.wdata;
    if (hit(cw, cpu_acc.off, pmd_pkg::OFF_OUT_MSG0))
      n.out_message_zero = cpu_acc.wdata;
    if (hit(cw, cpu_acc.off, pmd_pkg::OFF_OUT_MSG1))
      n.out_message_one = cpu_acc.wdata;
    // inbound causes, set wins over clear
    n.in_msg_cause[0] = (s.in_msg_cause[0] && !in_clr[pmd_pkg::IN_MSG0_BIT])
                        || hit(pw, pci_acc.off, pmd_pkg::OFF_IN_MSG0);
    n.in_msg_cause[1] = (s.in_msg_cause[1] && !in_clr[pmd_pkg::IN_MSG1_BIT])
                        || hit(pw, pci_acc.off, pmd_pkg::OFF_IN_MSG1);
    n.in_post_queue_event = (s.in_post_queue_event && !in_clr[pmd_pkg::IN_PQ_BIT])
                            || in_post_queue_write;
    n.fq_full_d = out_free_queue_full;
    n.out_free_queue_full_event = (s.out_free_queue_full_event
                                   && !in_clr[pmd_pkg::IN_FQ_BIT])
                                  || (out_free_queue_full && !s.fq_full_d);
    // outbound causes, pci clears
    n.out_msg_cause[0] = (s.out_msg_cause[0] && !out_clr[pmd_pkg::OUT_MSG0_BIT])
                         || hit(cw, cpu_acc.off, pmd_pkg::OFF_OUT_MSG0);
    n.out_msg_cause[1] = (s.out_msg_cause[1] && !out_clr[pmd_pkg::OUT_MSG1_BIT])
                         || hit(cw, cpu_acc.off, pmd_pkg::OFF_OUT_MSG1);
    // masks
    if (hit(cw, cpu_acc.off, pmd_pkg::OFF_IN_MASK))
      n.in_mask = cpu_acc.wdata[5:0] & pmd_pkg::IN_MASK_VALID;
    if (hit(pw, pci_acc.off, pmd_pkg::OFF_OUT_MASK))
      n.out_mask = pci_acc.wdata[3:0];
    // answers
    n.cpu_ack = cpu_acc.sel;
    n.cpu_rdata = cr ? reg_read(cpu_acc.off, s, in_cause_word, out_cause_word,
                                in_bell_bits, out_bell_bits) : pmd_pkg::WORD_RST;
    n.pci0_ack = pci_acc.sel;
    n.pci0_rdata = pr ? reg_read(pci_acc.off, s, in_cause_word, out_cause_word,
                                 in_bell_bits, out_bell_bits) : pmd_pkg::WORD_RST;
    n.pci0_to_sdram = pci_acc.miss;
    n.pci1_to_sdram = pci1_bar_valid;
    // interrupts registered from the cause words, outbound bit 3 taken straight from its input
    n.cpu_irq = |(in_cause_word & {26'h0, s.in_mask & pmd_pkg::IN_MASK_VALID} ^
                  (in_cause_word & pmd_pkg::IN_CAUSE_VALID));
    n.pci_irq = |(out_cause_word[3:0] & ~s.out_mask);
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '0;
      s.in_mask <= pmd_pkg::IN_MASK_RST;
      s.out_mask <= pmd_pkg::OUT_MASK_RST;
    end
    else
      s <= n;
  end

  assign cpu_ack = s.cpu_ack;
  assign cpu_rdata = s.cpu_rdata;
  assign pci0_ack = s.pci0_ack;
  assign pci0_rdata = s.pci0_rdata;
  assign pci0_to_sdram = s.pci0_to_sdram;
  assign pci1_to_sdram = s.pci1_to_sdram;
  assign cpu_irq = s.cpu_irq;
  assign pci_irq = s.pci_irq;

  strap_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s.strap_done && !s.enabled) |=> (!cpu_ack && !pci0_ack))
    else $error("access answered while disabled");

  pci1_route_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    pci1_bar_valid |=> pci1_to_sdram)
    else $error("second port not routed to sdram");

  pci0_miss_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    pci_acc.miss |=> (pci0_to_sdram && !pci0_ack))
    else $error("first port miss not routed to sdram");

  pci0_hit_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    pci_acc.sel |=> (pci0_ack && !pci0_to_sdram))
    else $error("first port hit not answered");

  cpu_ack_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cpu_acc.sel |=> cpu_ack)
    else $error("cpu hit not answered");

  cpu_miss_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !cpu_acc.sel |=> !cpu_ack)
    else $error("cpu answer without hit");

  in_msg_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    hit(pw, pci_acc.off, pmd_pkg::OFF_IN_MSG0)
    |=> (s.in_msg_cause[0] && s.in_message_zero == $past(pci0_wdata)))
    else $error("inbound message 0 write lost");

  in_msg1_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    hit(pw, pci_acc.off, pmd_pkg::OFF_IN_MSG1)
    |=> (s.in_msg_cause[1] && s.in_message_one == $past(pci0_wdata)))
    else $error("inbound message 1 write lost");

  out_msg_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    hit(cw, cpu_acc.off, pmd_pkg::OFF_OUT_MSG1)
    |=> (s.out_msg_cause[1] && s.out_message_one == $past(cpu_wdata)))
    else $error("outbound message 1 write lost");

  ro_view_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (hit(cw, cpu_acc.off, pmd_pkg::OFF_IN_MSG1)
     && !hit(pw, pci_acc.off, pmd_pkg::OFF_IN_MSG1))
    |=> $stable(s.in_message_one))
    else $error("cpu changed an inbound message");

  out_ro_view_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (hit(pw, pci_acc.off, pmd_pkg::OFF_OUT_MSG0)
     && !hit(cw, cpu_acc.off, pmd_pkg::OFF_OUT_MSG0))
    |=> $stable(s.out_message_zero))
    else $error("pci changed an outbound message");

  mask_ro_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (hit(pw, pci_acc.off, pmd_pkg::OFF_IN_MASK)
     && !hit(cw, cpu_acc.off, pmd_pkg::OFF_IN_MASK))
    |=> $stable(s.in_mask))
    else $error("pci changed the inbound mask");

  mask_rsvd_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s.in_mask & ~pmd_pkg::IN_MASK_VALID) == '0)
    else $error("reserved inbound mask bit set");

  set_wins_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (hit(pw, pci_acc.off, pmd_pkg::OFF_IN_MSG1) && in_clr[pmd_pkg::IN_MSG1_BIT])
    |=> s.in_msg_cause[1])
    else $error("message event lost to clear");

  pq_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    in_post_queue_write |=> s.in_post_queue_event)
    else $error("post queue event missed");

  cpu_irq_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (in_bell_bits != '0 && !s.in_mask[pmd_pkg::IN_BELL_BIT]) |=> cpu_irq)
    else $error("doorbell interrupt missing");

  cpu_irq_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ((in_cause_word & ~{26'h0, s.in_mask}) != '0) |=> cpu_irq)
    else $error("cpu interrupt missing");

  cpu_irq_quiet_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ((in_cause_word & ~{26'h0, s.in_mask}) == '0) |=> !cpu_irq)
    else $error("cpu interrupt without cause");

  pci_irq_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (|(out_cause_word[3:0] & ~s.out_mask)) |=> pci_irq)
    else $error("pci interrupt missing");

  cause_rsvd_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    hit(cr, cpu_acc.off, pmd_pkg::OFF_IN_CAUSE)
    ##1 1'b1 |-> ((cpu_rdata & ~pmd_pkg::IN_CAUSE_VALID) == '0))
    else $error("reserved cause bits not zero");

  fq_edge_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ($rose(out_free_queue_full) && s.strap_done) |=> s.out_free_queue_full_event)
    else $error("free queue full event missed");

endmodule

// *** sim/pmd_pci_master.sv ***
// Purpose: first pci port master model driving the sdram window of the unit
// Assumes: one request at a time, answer one clock after it is taken
// Notes: released address and data lines show the inverse of the last value
module pmd_pci_master (
  // clock
  input wire logic ref_clk,
  // request
  output logic valid,
  output logic wr,
  output logic [31:0] addr,
  output logic [31:0] wdata,
  // answer
  input wire logic ack,
  input wire logic [31:0] rdata,
  input wire logic to_sdram
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rd;
  logic ak;
  logic sd;

  initial
  begin
    valid = 1'b0;
    wr = 1'b0;
    addr = 32'h0000_0000;
    wdata = 32'h0000_0000;
  end

  // offsets are taken from the window base
  task automatic access(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    valid <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    valid <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    #1;
    rd = rdata;
    ak = ack;
    sd = to_sdram;
  endtask
endmodule

// *** sim/pmd_top_tb.sv ***
// Purpose: self-checking bench of the message and doorbell unit
// Assumes: cpu port driven here, first pci port through the master model
// Notes: answers are sampled just after the edge that registers them
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pmd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic messaging_enable_strap = 1'b0;
  logic cpu_valid = 1'b0;
  logic cpu_wr = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [31:0] cpu_wdata = 32'h0000_0000;
  logic cpu_ack;
  logic [31:0] cpu_rdata;
  logic p0_valid;
  logic p0_wr;
  logic [31:0] p0_addr;
  logic [31:0] p0_wdata;
  logic pci0_ack;
  logic [31:0] pci0_rdata;
  logic pci0_to_sdram;
  logic pci1_bar_valid = 1'b0;
  logic pci1_to_sdram;
  logic pq_wr = 1'b0;
  logic fq_full = 1'b0;
  logic opq = 1'b0;
  logic cpu_irq;
  logic pci_irq;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic ak;

  always #4 ref_clk = ~ref_clk;

  pmd_top i_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .messaging_enable_strap(messaging_enable_strap),
    .cpu_valid(cpu_valid), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
    .pci0_bar_valid(p0_valid), .pci0_wr(p0_wr), .pci0_addr(p0_addr),
    .pci0_wdata(p0_wdata), .pci0_ack(pci0_ack), .pci0_rdata(pci0_rdata),
    .pci0_to_sdram(pci0_to_sdram), .pci1_bar_valid(pci1_bar_valid),
    .pci1_to_sdram(pci1_to_sdram), .in_post_queue_write(pq_wr),
    .out_free_queue_full(fq_full), .out_post_queue_not_empty(opq),
    .cpu_irq(cpu_irq), .pci_irq(pci_irq)
  );

  pmd_pci_master i_pci (
    .ref_clk(ref_clk), .valid(p0_valid), .wr(p0_wr), .addr(p0_addr), .wdata(p0_wdata),
    .ack(pci0_ack), .rdata(pci0_rdata), .to_sdram(pci0_to_sdram)
  );

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic do_reset(input logic s);
    @(posedge ref_clk);
    messaging_enable_strap <= s;
    arst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
  endtask

  task automatic cpu_acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cpu_valid <= 1'b1;
    cpu_wr <= w;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge ref_clk);
    cpu_valid <= 1'b0;
    cpu_addr <= ~a;
    cpu_wdata <= ~d;
    #1;
    rd = cpu_rdata;
    ak = cpu_ack;
  endtask

  task automatic cpu_rd(input logic [15:0] a, input logic [31:0] e);
    cpu_acc(1'b0, a, 32'h0000_0000);
    `CHK(ak, 1'b1)
    `CHK(rd, e)
  endtask

  task automatic pci_rd(input logic [31:0] a, input logic [31:0] e);
    i_pci.access(1'b0, a, 32'h0000_0000);
    `CHK(i_pci.ak, 1'b1)
    `CHK(i_pci.rd, e)
  endtask

  task automatic irq(input logic c, input logic p);
    @(posedge ref_clk);
    #1;
    `CHK(cpu_irq, c)
    `CHK(pci_irq, p)
  endtask

  initial
  begin
    #200us;
    err_total++;
    complete_run();
  end

  initial
  begin
    do_reset(1'b0);
    for (int i = 0; i < 10; i++)
      cpu_rd(16'h1c10 + 16'(4 * i), 32'h0000_0000);
    cpu_rd(16'h1c40, 32'h0000_0000);
    $display("test reset values done");
    cpu_acc(1'b1, 16'h1c18, 32'ha5a5_0001);
    irq(1'b0, 1'b1);
    pci_rd(32'h018, 32'ha5a5_0001);
    pci_rd(32'h030, 32'h0000_0001);
    i_pci.access(1'b1, 32'h018, 32'h0000_0000);
    pci_rd(32'h018, 32'ha5a5_0001);
    cpu_acc(1'b1, 16'h1c30, 32'h0000_0001);
    pci_rd(32'h030, 32'h0000_0001);
    i_pci.access(1'b1, 32'h030, 32'h0000_0001);
    irq(1'b0, 1'b0);
    i_pci.access(1'b1, 32'h034, 32'h0000_000f);
    cpu_acc(1'b1, 16'h1c1c, 32'h0000_0002);
    pci_rd(32'h030, 32'h0000_0002);
    irq(1'b0, 1'b0);
    i_pci.access(1'b1, 32'h034, 32'h0000_0000);
    irq(1'b0, 1'b1);
    cpu_acc(1'b1, 16'h1c34, 32'h0000_000f);
    irq(1'b0, 1'b1);
    i_pci.access(1'b1, 32'h030, 32'h0000_0002);
    irq(1'b0, 1'b0);
    $display("test outbound messages done");
    i_pci.access(1'b1, 32'h010, 32'h0000_0011);
    i_pci.access(1'b1, 32'h014, 32'h0000_0022);
    cpu_rd(16'h1c10, 32'h0000_0011);
    cpu_rd(16'h1c14, 32'h0000_0022);
    cpu_rd(16'h1c24, 32'h0000_0003);
    irq(1'b1, 1'b0);
    cpu_acc(1'b1, 16'h1c10, 32'h0000_00ff);
    cpu_rd(16'h1c10, 32'h0000_0011);
    cpu_acc(1'b1, 16'h1c24, 32'h0000_0000);
    cpu_rd(16'h1c24, 32'h0000_0003);
    cpu_acc(1'b1, 16'h1c24, 32'h0000_0001);
    cpu_rd(16'h1c24, 32'h0000_0002);
    cpu_acc(1'b1, 16'h1c24, 32'h0000_0002);
    irq(1'b0, 1'b0);
    $display("test inbound messages done");
    i_pci.access(1'b1, 32'h020, 32'h0000_0005);
    cpu_rd(16'h1c20, 32'h0000_0005);
    cpu_rd(16'h1c24, 32'h0000_0004);
    irq(1'b1, 1'b0);
    cpu_acc(1'b1, 16'h1c24, 32'h0000_0004);
    cpu_rd(16'h1c24, 32'h0000_0004);
    cpu_acc(1'b1, 16'h1c20, 32'h0000_0001);
    cpu_rd(16'h1c20, 32'h0000_0004);
    irq(1'b1, 1'b0);
    cpu_acc(1'b1, 16'h1c20, 32'h0000_0004);
    cpu_rd(16'h1c24, 32'h0000_0000);
    irq(1'b0, 1'b0);
    $display("test inbound doorbell done");
    cpu_acc(1'b1, 16'h1c28, 32'hffff_ffff);
    cpu_rd(16'h1c28, 32'h0000_0037);
    i_pci.access(1'b1, 32'h020, 32'h8000_0000);
    i_pci.access(1'b1, 32'h010, 32'h0000_0001);
    @(posedge ref_clk);
    pq_wr <= 1'b1;
    fq_full <= 1'b1;
    @(posedge ref_clk);
    pq_wr <= 1'b0;
    irq(1'b0, 1'b0);
    cpu_rd(16'h1c24, 32'h0000_0035);
    cpu_acc(1'b1, 16'h1c28, 32'h0000_0000);
    irq(1'b1, 1'b0);
    i_pci.access(1'b1, 32'h028, 32'h0000_0037);
    irq(1'b1, 1'b0);
    cpu_acc(1'b1, 16'h1c20, 32'h8000_0000);
    cpu_acc(1'b1, 16'h1c24, 32'h0000_0033);
    cpu_rd(16'h1c24, 32'h0000_0000);
    irq(1'b0, 1'b0);
    $display("test masks and queue events done");
    cpu_acc(1'b1, 16'h1c2c, 32'h0000_0003);
    pci_rd(32'h02c, 32'h0000_0003);
    pci_rd(32'h030, 32'h0000_0004);
    irq(1'b0, 1'b1);
    i_pci.access(1'b1, 32'h02c, 32'h0000_0001);
    pci_rd(32'h02c, 32'h0000_0002);
    i_pci.access(1'b1, 32'h02c, 32'h0000_0002);
    irq(1'b0, 1'b0);
    @(posedge ref_clk);
    opq <= 1'b1;
    pci_rd(32'h030, 32'h0000_0008);
    irq(1'b0, 1'b1);
    @(posedge ref_clk);
    opq <= 1'b0;
    pci_rd(32'h030, 32'h0000_0000);
    irq(1'b0, 1'b0);
    $display("test outbound doorbell done");
    i_pci.access(1'b1, 32'h010, 32'h0000_0005);
    fork
      i_pci.access(1'b1, 32'h010, 32'h0000_0006);
      cpu_acc(1'b1, 16'h1c24, 32'h0000_0001);
    join
    cpu_rd(16'h1c24, 32'h0000_0001);
    cpu_rd(16'h1c10, 32'h0000_0006);
    $display("test set over clear done");
    cpu_acc(1'b0, 16'h1810, 32'h0000_0000);
    `CHK(ak, 1'b0)
    i_pci.access(1'b0, 32'h1010, 32'h0000_0000);
    `CHK({i_pci.sd, i_pci.ak}, 2'h2)
    i_pci.access(1'b0, 32'h020, 32'h0000_0000);
    `CHK({i_pci.sd, i_pci.ak}, 2'h1)
    @(posedge ref_clk);
    pci1_bar_valid <= 1'b1;
    @(posedge ref_clk);
    pci1_bar_valid <= 1'b0;
    #1;
    `CHK(pci1_to_sdram, 1'b1)
    $display("test address routing done");
    do_reset(1'b1);
    cpu_acc(1'b0, 16'h1c10, 32'h0000_0000);
    `CHK(ak, 1'b0)
    i_pci.access(1'b0, 32'h010, 32'h0000_0000);
    `CHK({i_pci.sd, i_pci.ak}, 2'h2)
    $display("test strap disable done");
    complete_run();
  end
endmodule
